// ### vmcfg_consts.vh
/*
  Constants for the voltmeter channel configuration handler: register
  offsets, command word fields, setting codes and reset defaults.
  Assumes it is included by its bare name from the design file.
*/
`ifndef VMCFG_CONSTS_VH
`define VMCFG_CONSTS_VH
// Register byte offsets
`define VMCFG_OFS_CMD 5'h00
`define VMCFG_OFS_STATUS 5'h04
`define VMCFG_OFS_TOKFMT 5'h08
`define VMCFG_OFS_REPLY0 5'h10
`define VMCFG_OFS_REPLY1 5'h14
`define VMCFG_OFS_REPLY2 5'h18
`define VMCFG_OFS_REPLY3 5'h1C
// Command word fields
`define VMCFG_OP_LSB 0
`define VMCFG_CH_LSB 4
`define VMCFG_QRY_BIT 7
`define VMCFG_KW_BIT 8
`define VMCFG_ARG_LSB 16
// Opcodes
`define VMCFG_OP_LOCAL 4'h0
`define VMCFG_OP_LFREQ 4'h1
`define VMCFG_OP_DISP 4'h2
`define VMCFG_OP_LOCK 4'h3
`define VMCFG_OP_SCALE 4'h4
`define VMCFG_OP_ATTEN 4'h5
`define VMCFG_OP_ACAL 4'h6
`define VMCFG_OP_FILT 4'h7
`define VMCFG_OP_AUTO 4'h8
// Auto keyword codes
`define VMCFG_KW_OFF 16'h0000
`define VMCFG_KW_ALL 16'h0001
`define VMCFG_KW_SCALE 16'h0002
`define VMCFG_KW_DIVIDER 16'h0003
`define VMCFG_KW_AUTOCAL_REGIME 16'h0004
`define VMCFG_KW_FILTER 16'h0005
// Auto mask bits
`define VMCFG_AB_SCALE 0
`define VMCFG_AB_DIV 1
`define VMCFG_AB_AUTOCAL_REGIME 2
`define VMCFG_AB_FILT 3
// Printed values
`define VMCFG_HZ_50 16'h0032
`define VMCFG_HZ_60 16'h003C
`define VMCFG_SC_20 16'h0014
`define VMCFG_SC_2 16'h0002
`define VMCFG_SC_1000 16'h03E8
`define VMCFG_SC_200 16'h00C8
// Scale codes held internally
`define VMCFG_SCODE_20 2'h0
`define VMCFG_SCODE_2 2'h1
`define VMCFG_SCODE_1000 2'h2
`define VMCFG_SCODE_200 2'h3
// Attenuator and autocal codes
`define VMCFG_ATT_OFF 2'h0
`define VMCFG_ATT_ON 2'h1
`define VMCFG_ATT_OUT 2'h2
`define VMCFG_ACAL_GND 2'h1
`define VMCFG_ACAL_REF4 2'h2
`define VMCFG_ACAL_REF3 2'h3
// Keyword form flag in a reply word
`define VMCFG_REPLY_KW 16'h8000
// Reset defaults
`define VMCFG_RST_DISP 1'h1
`define VMCFG_RST_LOCK 1'h1
`define VMCFG_RST_SCALE 2'h0
`define VMCFG_RST_ATT 2'h1
`define VMCFG_RST_ACAL 2'h2
`define VMCFG_RST_FILT 1'h0
`define VMCFG_RST_AUTO 4'h0
`endif

// ### vmcfg_core.v
/*
  Configuration command handler for a four-channel voltmeter.
  Commands arrive pre-tokenised as words over an Avalon-MM slave;
  per-channel settings drive the measurement and display logic.
  Assumes one 50 MHz clock, an external nonvolatile cell for the
  line frequency, and synchronous status inputs.
*/
`include "vmcfg_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module vmcfg_core (
  input wire sys_clk, // System clock
  input wire nrst, // Async reset, active low
  input wire [4:0] avs_address, // Byte address
  input wire avs_read, // Read strobe
  input wire avs_write, // Write strobe
  input wire [31:0] avs_writedata, // Write data
  output reg [31:0] avs_readdata, // Read data
  output wire avs_waitrequest, // Stall request
  input wire nv_freq_60, // Stored line frequency is 60 Hz
  output reg nv_wr_en, // Store new line frequency
  output reg nv_wr_60, // Value to store
  input wire [3:0] cal_done, // Autocal finished per channel
  input wire [7:0] meas_scale, // Measured scale code per channel
  input wire [3:0] button_in, // Panel button press per channel
  input wire [3:0] msg_in, // Remote message strobe per channel
  output reg [3:0] disp_show_reading, // Show new reading
  output reg [3:0] disp_blank, // Blank display
  output reg [3:0] disp_show_msg, // Show remote message
  output reg [3:0] button_accept, // Button press passed on
  output reg [7:0] scale_eff, // Effective scale code per channel
  output reg [7:0] atten_eff, // Effective attenuator code
  output reg [7:0] autocal_eff, // Effective autocal regime
  output reg [3:0] filter_eff, // Effective filter state
  output reg [3:0] ovp_high_limit, // 20 V protection limit
  output reg line_freq_60, // Line rejection at 60 Hz
  output reg trig_local // Pulse: trigger mode to local
);

  // Bus handshake state
  reg ack_q; // Answer cycle
  // Per-channel settings
  reg disp_q [0:3]; // Display enable
  reg lock_q [0:3]; // 1 normal, 0 locked out
  reg [1:0] scale_q [0:3]; // Scale code
  reg [1:0] att_q [0:3]; // Attenuator code
  reg [1:0] acal_q [0:3]; // Autocal regime
  reg filt_q [0:3]; // Filter state
  reg [3:0] auto_q [0:3]; // Autorange mask
  // Global state
  reg tokfmt_q; // 1 keyword replies
  reg rej_q; // Last command rejected
  reg [2:0] rcnt_q; // Reply count
  reg [15:0] reply_q [0:3]; // Reply words
  reg nv_load_q; // Loads stored frequency after reset
  // Command decode
  wire cmd_go; // Command write accepted
  wire [3:0] op; // Opcode
  wire [2:0] ch; // Channel field
  wire qry; // Query form
  wire kw; // Argument given as keyword
  wire [15:0] arg; // Argument
  wire ch_bad; // Channel out of range
  wire op_bad; // Opcode not in the command set
  reg arg_bad; // Argument out of range
  integer i; // Channel loop index

  assign cmd_go = avs_write & ack_q & (avs_address == `VMCFG_OFS_CMD);
  assign op = avs_writedata[`VMCFG_OP_LSB +: 4];
  assign ch = avs_writedata[`VMCFG_CH_LSB +: 3];
  assign qry = avs_writedata[`VMCFG_QRY_BIT];
  assign kw = avs_writedata[`VMCFG_KW_BIT];
  assign arg = avs_writedata[`VMCFG_ARG_LSB +: 16];
  // Channel 0 means all four; anything past 4 is refused
  assign ch_bad = (ch > 3'h4);
  assign op_bad = (op > `VMCFG_OP_AUTO);
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  // Maps a printed scale value to its code
  function [1:0] scale_code;
    input [15:0] v;
    begin
      case (v)
        `VMCFG_SC_2: scale_code = `VMCFG_SCODE_2;
        `VMCFG_SC_1000: scale_code = `VMCFG_SCODE_1000;
        `VMCFG_SC_200: scale_code = `VMCFG_SCODE_200;
        default: scale_code = `VMCFG_SCODE_20;
      endcase
    end
  endfunction

  // Maps a scale code back to its printed value
  function [15:0] scale_val;
    input [1:0] c;
    begin
      case (c)
        `VMCFG_SCODE_2: scale_val = `VMCFG_SC_2;
        `VMCFG_SCODE_1000: scale_val = `VMCFG_SC_1000;
        `VMCFG_SCODE_200: scale_val = `VMCFG_SC_200;
        default: scale_val = `VMCFG_SC_20;
      endcase
    end
  endfunction

  // Formats a token reply in the chosen form
  function [15:0] tok_reply;
    input [1:0] c;
    input kwf;
    begin
      tok_reply = {14'h0000, c} | (kwf ? `VMCFG_REPLY_KW : 16'h0000);
    end
  endfunction

  // Channel selected by the channel field
  function ch_sel;
    input [2:0] c;
    input [1:0] n;
    begin
      ch_sel = (c == 3'h0) | (c == {1'b0, n} + 3'h1);
    end
  endfunction

  // Channel whose setting fills reply slot n
  function [1:0] reply_src;
    input [2:0] c;
    input [1:0] n;
    begin
      reply_src = (c == 3'h0) ? n : (c[1:0] - 2'h1);
    end
  endfunction

  // Validates set arguments
  always @* begin
    arg_bad = 1'b0;
    case (op)
      `VMCFG_OP_LFREQ: arg_bad = (arg != `VMCFG_HZ_50) & (arg != `VMCFG_HZ_60);
      `VMCFG_OP_DISP, `VMCFG_OP_LOCK, `VMCFG_OP_FILT: arg_bad = (arg > 16'h0001);
      `VMCFG_OP_SCALE: arg_bad = (arg != `VMCFG_SC_20) & (arg != `VMCFG_SC_2) &
                                 (arg != `VMCFG_SC_1000) & (arg != `VMCFG_SC_200);
      `VMCFG_OP_ATTEN: arg_bad = (arg > 16'h0002);
      `VMCFG_OP_ACAL: arg_bad = (arg > 16'h0003);
      `VMCFG_OP_AUTO: arg_bad = kw ? (arg > `VMCFG_KW_FILTER) : (arg > 16'h000F);
      `VMCFG_OP_LOCAL: arg_bad = 1'b0;
      default: arg_bad = 1'b1;
    endcase
  end

  // Bus answer: one wait cycle, then the request completes
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else begin
      // Exactly one wait state: the stall drops one cycle after the request
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read & ~ack_q) begin
        case (avs_address)
          `VMCFG_OFS_STATUS: avs_readdata <= {27'h0000000, rcnt_q, tokfmt_q, rej_q};
          `VMCFG_OFS_TOKFMT: avs_readdata <= {31'h00000000, tokfmt_q};
          `VMCFG_OFS_REPLY0: avs_readdata <= {16'h0000, reply_q[0]};
          `VMCFG_OFS_REPLY1: avs_readdata <= {16'h0000, reply_q[1]};
          `VMCFG_OFS_REPLY2: avs_readdata <= {16'h0000, reply_q[2]};
          `VMCFG_OFS_REPLY3: avs_readdata <= {16'h0000, reply_q[3]};
          default: avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Line frequency: loaded from the nonvolatile cell after reset
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      nv_load_q <= 1'b1;
      line_freq_60 <= 1'b0;
      nv_wr_en <= 1'b0;
      nv_wr_60 <= 1'b0;
    end else begin
      nv_load_q <= 1'b0;
      nv_wr_en <= 1'b0;
      if (nv_load_q) begin
        line_freq_60 <= nv_freq_60;
      end else if (cmd_go & ~qry & ~ch_bad & ~arg_bad & (op == `VMCFG_OP_LFREQ)) begin
        // A refused command must not reach the nonvolatile cell
        // store accepted value
        line_freq_60 <= (arg == `VMCFG_HZ_60);
        nv_wr_en <= 1'b1;
        nv_wr_60 <= (arg == `VMCFG_HZ_60);
      end
    end
  end

  // Command execution and per-channel settings
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      tokfmt_q <= 1'b0;
      rej_q <= 1'b0;
      rcnt_q <= 3'h0;
      trig_local <= 1'b0;
      disp_blank <= 4'h0;
      for (i = 0; i < 4; i = i + 1) begin
        disp_q[i] <= `VMCFG_RST_DISP;
        lock_q[i] <= `VMCFG_RST_LOCK;
        scale_q[i] <= `VMCFG_RST_SCALE;
        att_q[i] <= `VMCFG_RST_ATT;
        acal_q[i] <= `VMCFG_RST_ACAL;
        filt_q[i] <= `VMCFG_RST_FILT;
        auto_q[i] <= `VMCFG_RST_AUTO;
        reply_q[i] <= 16'h0000;
      end
    end else begin
      trig_local <= 1'b0;
      disp_blank <= 4'h0;
      if (avs_write & ack_q & (avs_address == `VMCFG_OFS_TOKFMT)) begin
        tokfmt_q <= avs_writedata[0];
      end
      if (cmd_go) begin
        // Unknown opcodes are refused for queries as well as sets
        rej_q <= ch_bad | op_bad | (~qry & arg_bad);
        if (qry & ~ch_bad & ~op_bad) begin
          rcnt_q <= ((ch == 3'h0) & (op != `VMCFG_OP_LFREQ)) ? 3'h4 : 3'h1;
          // Slot i takes channel i+1 on an all-channel query
          for (i = 0; i < 4; i = i + 1) begin
            case (op)
              `VMCFG_OP_LFREQ: reply_q[i] <= line_freq_60 ? `VMCFG_HZ_60 : `VMCFG_HZ_50;
              `VMCFG_OP_DISP: reply_q[i] <= tok_reply({1'b0, disp_q[reply_src(ch, i[1:0])]}, tokfmt_q);
              `VMCFG_OP_LOCK: reply_q[i] <= tok_reply({1'b0, lock_q[reply_src(ch, i[1:0])]}, tokfmt_q);
              `VMCFG_OP_SCALE: reply_q[i] <= scale_val(scale_q[reply_src(ch, i[1:0])]);
              `VMCFG_OP_ATTEN: reply_q[i] <= tok_reply(att_q[reply_src(ch, i[1:0])], tokfmt_q);
              `VMCFG_OP_ACAL: reply_q[i] <= tok_reply(acal_q[reply_src(ch, i[1:0])], tokfmt_q);
              `VMCFG_OP_FILT: reply_q[i] <= tok_reply({1'b0, filt_q[reply_src(ch, i[1:0])]}, tokfmt_q);
              `VMCFG_OP_AUTO: reply_q[i] <= {12'h000, auto_q[reply_src(ch, i[1:0])]};
              default: reply_q[i] <= 16'h0000;
            endcase
          end
        end else if (~qry & ~ch_bad & ~arg_bad) begin
          rcnt_q <= 3'h0;
          if (op == `VMCFG_OP_LOCAL) begin
            trig_local <= 1'b1;
          end
          for (i = 0; i < 4; i = i + 1) begin
            if (ch_sel(ch, i[1:0]) | (op == `VMCFG_OP_LOCAL)) begin
              case (op)
                `VMCFG_OP_LOCAL: begin
                  auto_q[i] <= 4'h0;
                  att_q[i] <= (scale_q[i] == `VMCFG_SCODE_20) ? `VMCFG_ATT_ON : `VMCFG_ATT_OFF;
                end
                `VMCFG_OP_DISP: begin
                  disp_q[i] <= arg[0];
                  disp_blank[i] <= ~arg[0];
                end
                `VMCFG_OP_LOCK: lock_q[i] <= arg[0];
                `VMCFG_OP_SCALE: scale_q[i] <= scale_code(arg);
                `VMCFG_OP_ATTEN: att_q[i] <= arg[1:0];
                `VMCFG_OP_ACAL: acal_q[i] <= arg[1:0];
                `VMCFG_OP_FILT: filt_q[i] <= arg[0];
                `VMCFG_OP_AUTO: begin
                  if (!kw) begin
                    auto_q[i] <= arg[3:0];
                  end else if (arg == `VMCFG_KW_OFF) begin
                    auto_q[i] <= 4'h0;
                  end else if (arg == `VMCFG_KW_ALL) begin
                    auto_q[i] <= 4'hF;
                  end else begin
                    auto_q[i] <= auto_q[i] | (4'h1 << (arg[2:0] - 3'h2));
                  end
                end
                default: auto_q[i] <= auto_q[i];
              endcase
            end
          end
        end
      end
    end
  end

  // Effective settings and display events per channel
  always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      scale_eff <= 8'h00;
      atten_eff <= 8'h00;
      autocal_eff <= 8'h00;
      filter_eff <= 4'h0;
      ovp_high_limit <= 4'h0;
      disp_show_reading <= 4'h0;
      disp_show_msg <= 4'h0;
      button_accept <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        scale_eff[2*i +: 2] <= auto_q[i][`VMCFG_AB_SCALE] ? meas_scale[2*i +: 2] : scale_q[i];
        if (auto_q[i][`VMCFG_AB_DIV]) begin
          atten_eff[2*i +: 2] <= (scale_q[i] == `VMCFG_SCODE_20) ? `VMCFG_ATT_ON : `VMCFG_ATT_OUT;
        end else begin
          atten_eff[2*i +: 2] <= att_q[i];
        end
        if (auto_q[i][`VMCFG_AB_DIV]) begin
          ovp_high_limit[i] <= (scale_q[i] == `VMCFG_SCODE_20);
        end else begin
          ovp_high_limit[i] <= (att_q[i] == `VMCFG_ATT_ON);
        end
        if (auto_q[i][`VMCFG_AB_AUTOCAL_REGIME]) begin
          autocal_eff[2*i +: 2] <= scale_q[i][1] ? `VMCFG_ACAL_REF3 : `VMCFG_ACAL_REF4;
        end else begin
          autocal_eff[2*i +: 2] <= acal_q[i];
        end
        filter_eff[i] <= auto_q[i][`VMCFG_AB_FILT] ? scale_q[i][1] : filt_q[i];
        disp_show_reading[i] <= cal_done[i] & disp_q[i];
        disp_show_msg[i] <= msg_in[i];
        button_accept[i] <= button_in[i] & lock_q[i];
      end
    end
  end

endmodule
`default_nettype wire

// ### vmcfg_core_chk.sv
/* Checker for vmcfg_core: bus timing, display, button and line-frequency relations.
   Assumes it is bound to the design top and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module vmcfg_core_chk (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset, active low
  input wire logic avs_read, // Read strobe
  input wire logic avs_write, // Write strobe
  input wire logic avs_waitrequest, // Stall
  input wire logic [3:0] cal_done, // Calibration done
  input wire logic [3:0] button_in, // Button presses
  input wire logic [3:0] msg_in, // Message strobes
  input wire logic [3:0] disp_show_reading, // Reading shown
  input wire logic [3:0] disp_blank, // Blank pulse
  input wire logic [3:0] disp_show_msg, // Message shown
  input wire logic [3:0] button_accept, // Buttons passed on
  input wire logic [7:0] atten_eff, // Effective attenuator
  input wire logic [3:0] ovp_high_limit, // High trip limit
  input wire logic nv_wr_en, // Store strobe
  input wire logic nv_wr_60, // Stored value
  input wire logic line_freq_60, // Line frequency
  input wire logic trig_local // Local trigger pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Expected high limit per channel from attenuator codes
  function automatic logic [3:0] ovp_of(input logic [7:0] a);
    for (int i = 0; i < 4; i++) ovp_of[i] = (a[2*i +: 2] == 2'h1);
  endfunction
  a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request stalled beyond one cycle");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("stall raised without a request");
  a_show_cause: assert property ((disp_show_reading & ~$past(cal_done)) == 4'h0)
    else $error("reading shown without calibration done");
  a_msg_follow: assert property ($past(nrst) |-> disp_show_msg == $past(msg_in))
    else $error("message strobe not passed to display");
  a_button_cause: assert property ((button_accept & ~$past(button_in)) == 4'h0)
    else $error("button accepted without a press");
  a_ovp_track: assert property ($stable(atten_eff) |-> ovp_high_limit == ovp_of(atten_eff))
    else $error("trip limit does not follow attenuator");
  a_lf_store: assert property (nv_wr_en |-> line_freq_60 == nv_wr_60)
    else $error("stored and active line frequency differ");
  a_lf_hold: assert property ($past(nrst, 2) && $past(nrst) && !nv_wr_en |-> $stable(line_freq_60))
    else $error("line frequency changed without a store");
  a_trig_pulse: assert property (trig_local |=> !trig_local)
    else $error("local trigger longer than one cycle");
  a_blank_pulse: assert property ((disp_blank & $past(disp_blank)) == 4'h0)
    else $error("blank pulse longer than one cycle");
endmodule
bind vmcfg_core vmcfg_core_chk u_vmcfg_core_chk (
  .sys_clk(sys_clk), .nrst(nrst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .cal_done(cal_done), .button_in(button_in), .msg_in(msg_in),
  .disp_show_reading(disp_show_reading), .disp_blank(disp_blank), .disp_show_msg(disp_show_msg),
  .button_accept(button_accept), .atten_eff(atten_eff), .ovp_high_limit(ovp_high_limit),
  .nv_wr_en(nv_wr_en), .nv_wr_60(nv_wr_60), .line_freq_60(line_freq_60), .trig_local(trig_local)
);
`default_nettype wire

// ### vmcfg_core_tb.sv
/* Self-checking bench for vmcfg_core with random status pulses.
   Assumes the design, its bound checker and the cell model. */
`timescale 1ns/1ps
`default_nettype none
module vmcfg_core_tb;
  logic sys_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0; // Clock, reset, strobes
  logic [4:0] avs_address = 5'h00; // Address
  logic [31:0] avs_writedata = 32'h00000000, seed = 32'h00006B00; // Write data, random state
  logic [3:0] cal_done = 4'h0, button_in = 4'h0, msg_in = 4'h0; // Status pulses
  logic [7:0] meas_scale = 8'h00; // Measured scales
  logic [7:0] ms_q = 8'h00; // Measured scales as the design last sampled them
  logic [3:0] cd_q = 4'h0, bt_q = 4'h0; // Calibration and button inputs as last sampled
  wire [31:0] avs_readdata;
  wire avs_waitrequest, nv_wr_en, nv_wr_60, nv_freq_60, line_freq_60, trig_local;
  wire [3:0] disp_show_reading, disp_blank, disp_show_msg, button_accept, filter_eff, ovp_high_limit;
  wire [7:0] scale_eff, atten_eff, autocal_eff;
  int fails = 0, n_checks = 0, n_trig = 0, n_blank = 0, n_nv = 0;
  logic [16:0] at [9] = '{17'h00005, 17'h10000, 17'h10002, 17'h10003, 17'h10004, 17'h10005, 17'h10000, 17'h10001, 17'h0000A};
  logic [3:0] am [9] = '{4'h5, 4'h0, 4'h1, 4'h3, 4'h7, 4'hF, 4'h0, 4'hF, 4'hA};
  always #10 sys_clk = ~sys_clk;
  vmcfg_core u_vmcfg_core (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .nv_freq_60(nv_freq_60), .nv_wr_en(nv_wr_en), .nv_wr_60(nv_wr_60),
    .cal_done(cal_done), .meas_scale(meas_scale), .button_in(button_in), .msg_in(msg_in),
    .disp_show_reading(disp_show_reading), .disp_blank(disp_blank), .disp_show_msg(disp_show_msg),
    .button_accept(button_accept), .scale_eff(scale_eff), .atten_eff(atten_eff), .autocal_eff(autocal_eff),
    .filter_eff(filter_eff), .ovp_high_limit(ovp_high_limit), .line_freq_60(line_freq_60),
    .trig_local(trig_local));
  vmcfg_nvcell u_vmcfg_nvcell (.sys_clk(sys_clk), .wr_en(nv_wr_en), .wr_60(nv_wr_60), .freq_60(nv_freq_60));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // Random status pulses and pulse counters
  always @(posedge sys_clk) begin
    seed <= xs(seed);
    cal_done <= seed[3:0];
    button_in <= seed[7:4];
    msg_in <= seed[11:8];
    meas_scale <= seed[19:12];
    ms_q <= meas_scale;
    cd_q <= cal_done;
    bt_q <= button_in;
    if (trig_local === 1'b1) n_trig <= n_trig + 1;
    if (disp_blank !== 4'h0) n_blank <= n_blank + 1;
    if (nv_wr_en === 1'b1) n_nv <= n_nv + 1;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One bus transfer held until the stall drops
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= d;
    // Stall is sampled at rising edges; data is taken at the one where it is low
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      $display("[ERR] avs_waitrequest expected 0 seen %b", avs_waitrequest);
    end
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic cmd(input logic [3:0] op, input logic [2:0] ch, input logic q, input logic kw, input logic [15:0] arg);
    logic [31:0] x;
    bus(1'b1, 5'h00, {arg, 7'h00, kw, q, ch, op}, x);
  endtask
  task automatic qry(input logic [3:0] op, input logic [2:0] ch, output logic [15:0] r);
    logic [31:0] x;
    cmd(op, ch, 1'b1, 1'b0, 16'h0000);
    bus(1'b0, 5'h10, 32'h0, x);
    r = x[15:0];
  endtask
  // Printed value of code k; one past the last code is invalid
  function automatic logic [15:0] cval(input int op, input int k);
    if (op == 4) return (k == 0) ? 16'h0014 : (k == 1) ? 16'h0002 : (k == 2) ? 16'h03E8 : (k == 3) ? 16'h00C8 : 16'h0005;
    return 16'(k);
  endfunction
  function automatic int ncodes(input int op);
    return (op == 4 || op == 6) ? 4 : (op == 5) ? 3 : 2;
  endfunction
  function automatic logic [15:0] eff(input int op, input logic [2:0] ch);
    int b;
    b = 2 * (ch - 1);
    case (op)
      4: return {14'h0, scale_eff[b +: 2]};
      5: return {14'h0, atten_eff[b +: 2]};
      6: return {14'h0, autocal_eff[b +: 2]};
      default: return {15'h0, filter_eff[ch - 3'h1]};
    endcase
  endfunction
  task automatic complete_run;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #400000;
    fails++;
    complete_run();
  end
  initial begin
    logic [31:0] x;
    logic [15:0] r;
    logic [2:0] ch;
    int kk, nt;
    logic e1, g1;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("line_freq_60", 16'h1, {15'h0, line_freq_60});
    // Every code of each setting from display to filter, then one invalid value
    for (int op = 2; op < 8; op++) begin
      ch = {1'b0, seed[1:0]} + 3'h1;
      for (int k = 0; k <= ncodes(op); k++) begin
        kk = (k == ncodes(op)) ? k - 1 : k;
        cmd(4'(op), ch, 1'b0, 1'b0, cval(op, k));
        bus(1'b0, 5'h04, 32'h0, x);
        chk("reject", {15'h0, k == ncodes(op)}, {15'h0, x[0]});
        qry(4'(op), ch, r);
        chk("reply", cval(op, kk), r);
        if (op > 3) chk("effective", 16'(kk), eff(op, ch));
        // Off or locked: nothing passes; on or normal: each sampled input passes
        if (op < 4 && k < 2) repeat (8) begin
          @(negedge sys_clk);
          e1 = (k == 1) & ((op == 2) ? cd_q[ch - 3'h1] : bt_q[ch - 3'h1]);
          g1 = (op == 2) ? disp_show_reading[ch - 3'h1] : button_accept[ch - 3'h1];
          chk("gated", {15'h0, e1}, {15'h0, g1});
        end
      end
    end
    qry(4'h7, (ch == 3'h4) ? 3'h1 : ch + 3'h1, r);
    chk("other_channel", 16'h0, r);
    cmd(4'h7, 3'h0, 1'b0, 1'b0, 16'h0001);
    cmd(4'h7, 3'h0, 1'b1, 1'b0, 16'h0000);
    bus(1'b0, 5'h04, 32'h0, x);
    chk("reply_count", 16'h4, {13'h0, x[4:2]});
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, 5'(16 + 4 * i), 32'h0, x);
      chk("all_reply", 16'h1, x[15:0]);
    end
    chk("filter_all", 16'hF, {12'h0, filter_eff});
    cmd(4'h7, 3'h5, 1'b0, 1'b0, 16'h0000);
    bus(1'b0, 5'h04, 32'h0, x);
    chk("bad_channel", 16'h1, {15'h0, x[0]});
    chk("filter_kept", 16'hF, {12'h0, filter_eff});
    cmd(4'h9, 3'h1, 1'b1, 1'b0, 16'h0000);
    bus(1'b0, 5'h04, 32'h0, x);
    chk("bad_op", 16'h1, {15'h0, x[0]});
    for (int i = 0; i < 9; i++) begin
      cmd(4'h8, ch, 1'b0, at[i][16], at[i][15:0]);
      qry(4'h8, ch, r);
      chk("auto_mask", {12'h0, am[i]}, r);
    end
    bus(1'b1, 5'h08, 32'h1, x);
    qry(4'h8, ch, r);
    chk("auto_integer", 16'h000A, r);
    qry(4'h7, ch, r);
    chk("token_reply", 16'h8001, r);
    bus(1'b1, 5'h08, 32'h0, x);
    // Mask is divider plus filter here; scale 1000 drives both
    cmd(4'h4, ch, 1'b0, 1'b0, 16'h03E8);
    repeat (2) @(negedge sys_clk);
    chk("auto_atten", 16'h2, eff(5, ch));
    chk("auto_filter", 16'h1, eff(7, ch));
    chk("auto_limit", 16'h0, {15'h0, ovp_high_limit[ch - 3'h1]});
    cmd(4'h8, ch, 1'b0, 1'b0, 16'h0001);
    repeat (2) @(negedge sys_clk);
    chk("auto_scale", {14'h0, ms_q[2 * (ch - 3'h1) +: 2]}, eff(4, ch));
    nt = n_nv;
    cmd(4'h1, 3'h1, 1'b0, 1'b0, 16'h0032);
    cmd(4'h1, 3'h1, 1'b0, 1'b0, 16'h0037);
    cmd(4'h1, 3'h6, 1'b0, 1'b0, 16'h003C);
    qry(4'h1, 3'h1, r);
    chk("line_freq", 16'h0032, r);
    chk("store_writes", 16'h1, 16'(n_nv - nt));
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("line_freq_kept", 16'h0, {15'h0, line_freq_60});
    nt = n_trig;
    cmd(4'h8, 3'h2, 1'b0, 1'b1, 16'h0001);
    cmd(4'h0, 3'h0, 1'b0, 1'b0, 16'h0000);
    repeat (3) @(negedge sys_clk);
    chk("local_trigger", 16'h1, 16'(n_trig - nt));
    qry(4'h8, 3'h2, r);
    chk("local_auto", 16'h0, r);
    chk("blank_seen", 16'h1, {15'h0, n_blank > 0});
    complete_run();
  end
endmodule
`default_nettype wire

// ### vmcfg_nvcell.sv
/* Nonvolatile line-frequency cell on the far side of the handler.
   Assumes store strobes last one system clock cycle. */
`timescale 1ns/1ps
`default_nettype none
module vmcfg_nvcell #(parameter bit INIT_60 = 1'b1) (
  input wire logic sys_clk, // Clock
  input wire logic wr_en, // Store strobe
  input wire logic wr_60, // Value to store
  output var logic freq_60 // Stored value, high for 60 Hz
);
  initial freq_60 = INIT_60;
  // No reset input: only a store strobe changes the cell
  always @(posedge sys_clk) begin
    if (wr_en === 1'b1) begin
      freq_60 <= wr_60;
    end
  end
endmodule
`default_nettype wire
